//--- core/acm_pkg.sv
// Shared constants and types of the autonomous channel monitor.
// Assumes a 100 MHz core clock; all times are converted to cycles here.
package acm_pkg;
  // ----------------------------------------------------------------
  // Channels and widths
  // ----------------------------------------------------------------
  localparam int NCH = 10;
  localparam int NAIN = 8;
  localparam int NPAIR = 4;
  localparam int RES_BITS = 10;
  localparam int RAW_BITS = 11;
  localparam int FLT_BITS = 4;
  localparam int WAIT_BITS = 4;
  localparam int TX_BITS = 24;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam int AVG_LOG = 2;
  localparam logic [1:0] AVG_LAST = 2'h3;
  localparam logic [3:0] ADDR_TEMP = 4'h0;
  localparam logic [3:0] ADDR_ANALOG_INPUT_0 = 4'h2;
  localparam logic [3:0] SEL_GND = 4'hF;
  // ----------------------------------------------------------------
  // Times
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_CONV_NS = 10600;
  localparam int T_TEMP_NS = 46000;
  localparam int T_ACQ_NS = 1500;
  localparam int T_WAIT_NS = 10000;
  localparam int CONV_CYC = T_CONV_NS / CLK_NS;
  localparam int TEMP_CYC = T_TEMP_NS / CLK_NS;
  localparam int ACQ_CYC = T_ACQ_NS / CLK_NS;
  localparam int WAIT_CYC = T_WAIT_NS / CLK_NS;
  // ----------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MANUAL = 4'h0;
  localparam logic [3:0] CMD_RD_ALARM = 4'h1;
  localparam logic [3:0] CMD_RD_DATA = 4'h2;
  localparam logic [3:0] CMD_RESET = 4'h7;
  localparam logic [3:0] CMD_CLR_SEL = 4'h8;
  localparam logic [3:0] CMD_CLR_ALL = 4'h9;
  typedef enum logic [1:0] {
    ACM_IDLE = 2'b00,
    ACM_CONV = 2'b01,
    ACM_WAIT = 2'b10
  } acm_state_e;
endpackage

//--- core/acm_if.sv
// Carriers between the monitor core, its serial port and its conversion timer.
// Assumes all three sit on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface acm_ser_if;
  logic cmd_stb;
  logic [acm_pkg::CMD_BITS-1:0] cmd;
  logic cs_rise;
  logic [acm_pkg::TX_BITS-1:0] tx;
  modport port (output cmd_stb, cmd, cs_rise, input tx);
  modport core (input cmd_stb, cmd, cs_rise, output tx);
endinterface

interface acm_conv_if;
  logic start;
  logic temp;
  logic acq;
  logic signed [acm_pkg::RAW_BITS-1:0] code;
  logic done;
  logic signed [acm_pkg::RAW_BITS:0] res;
  modport conv (input start, temp, acq, code, output done, res);
  modport core (output start, temp, acq, code, input done, res);
endinterface
`default_nettype wire

//--- core/acm_spi.sv
// Serial slave port: command capture and read-back shifter.
// Assumes pin inputs are asynchronous to mclk_i and the link clock is slow.
`timescale 1ns/1ps
`default_nettype none
module acm_spi (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  acm_ser_if.port s
);
  import acm_pkg::*;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [1:0] s3;
    logic [4:0] bitc;
    logic [CMD_BITS-1:0] cmd;
    logic [TX_BITS-1:0] sh;
    logic dout;
    logic oe;
    logic stb;
    logic rise;
  } acm_spi_s;
  acm_spi_s q, next_q;
  // The synchronisers wake at the idle select level, so reset shows no false select edge and no drive.
  localparam acm_spi_s RST_Q = '{s1: 3'h4, s2: 3'h4, s3: 2'h2, default: '0};
  logic cs, rise, fall;
  assign cs = q.s2[2];
  assign rise = !q.s3[0] && q.s2[1];
  assign fall = q.s3[0] && !q.s2[1];

  always_comb begin
    next_q = q;
    next_q.s1 = {cs_n_i, sclk_i, din_i};
    next_q.s2 = q.s1;
    next_q.s3 = q.s2[2:1];
    next_q.stb = 1'b0;
    next_q.rise = cs && !q.s3[1];
    next_q.oe = !cs;
    if (cs) begin
      next_q.bitc = 5'h00;
      next_q.cmd = '0;
      next_q.sh = '0;
      next_q.dout = 1'b0;
    end else if (rise && q.bitc < CMD_BITS) begin
      next_q.cmd = {q.cmd[CMD_BITS-2:0], q.s2[0]};
      next_q.bitc = q.bitc + 5'h01;
      next_q.stb = (q.bitc == CMD_BITS - 5'h01);
    end else if (fall && q.bitc == CMD_BITS) begin
      next_q.dout = s.tx[TX_BITS-1];
      next_q.sh = {s.tx[TX_BITS-2:0], 1'b0};
      next_q.bitc = q.bitc + 5'h01;
    end else if (fall && q.bitc > CMD_BITS) begin
      next_q.dout = q.sh[TX_BITS-1];
      next_q.sh = {q.sh[TX_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= RST_Q;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign dout_o = q.dout;
  assign dout_oe_o = q.oe;
  assign s.cmd_stb = q.stb;
  assign s.cmd = q.cmd;
  assign s.cs_rise = q.rise;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i || !ce_i);
  a_dout_hiz_cs: assert property (cs |=> !q.oe && !q.dout) else $error("dout driven with select high");
  a_cmd_on_rise: assert property (q.stb |-> $past(rise) && $past(q.bitc) == 5'h07)
    else $error("command taken off a rising edge");
  a_dout_on_fall: assert property ($changed(q.dout) && $past(!cs) |-> $past(fall))
    else $error("dout moved off a falling edge");
endmodule // acm_spi
`default_nettype wire

//--- core/acm_conv.sv
// Conversion timer: acquisition, voltage and two-step temperature timing.
// Assumes the front end presents a settled signed code on the conv carrier.
`timescale 1ns/1ps
`default_nettype none
module acm_conv #(
  parameter int TEMP_CYCLES = acm_pkg::TEMP_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  acm_conv_if.conv c
);
  import acm_pkg::*;
  typedef struct packed {
    logic busy;
    logic done;
    logic temp;
    logic acq;
    logic [12:0] cnt;
    logic [12:0] half;
    logic [12:0] el;
    logic signed [RAW_BITS-1:0] first;
    logic signed [RAW_BITS:0] res;
  } acm_conv_s;
  acm_conv_s q, next_q;

  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (!q.busy) begin
      if (c.start) begin
        next_q.busy = 1'b1;
        next_q.temp = c.temp;
        next_q.acq = c.acq;
        next_q.el = 13'h0000;
        next_q.cnt = 13'(c.acq ? ACQ_CYC : 0) + 13'(c.temp ? TEMP_CYCLES : CONV_CYC);
        next_q.half = 13'(c.temp ? TEMP_CYCLES / 2 : 0);
      end
    end else begin
      next_q.cnt = q.cnt - 13'h0001;
      next_q.el = q.el + 13'h0001;
      if (q.temp && q.cnt == q.half) begin
        next_q.first = c.code;
      end
      if (q.cnt == 13'h0001) begin
        next_q.busy = 1'b0;
        next_q.done = 1'b1;
        next_q.res = q.temp ? $signed({c.code[RAW_BITS-1], c.code}) - $signed({q.first[RAW_BITS-1], q.first})
                            : $signed({c.code[RAW_BITS-1], c.code});
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign c.done = q.done;
  assign c.res = q.res;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i || !ce_i);
  a_volt_conv_time: assert property (q.done && !q.temp && !q.acq |-> q.el == 13'(CONV_CYC))
    else $error("voltage conversion length wrong");
  a_temp_conv_time: assert property (q.done && q.temp && !q.acq |-> q.el == 13'(TEMP_CYCLES))
    else $error("temperature conversion length wrong");
  a_manual_acq_time: assert property (q.done && !q.temp && q.acq |-> q.el == 13'(ACQ_CYC + CONV_CYC))
    else $error("manual acquisition plus conversion length wrong");
endmodule // acm_conv
`default_nettype wire

//--- core/acm_top.sv
// Autonomous channel monitor: scan sequencer, coding, averaging, limits,
// fault counting, alarm register, interrupt pin and serial command decode.
// Assumes configuration ports and the converter code share mclk_i; serial pins
// are asynchronous and are synchronised in the port module.
`timescale 1ns/1ps
`default_nettype none
module acm_top #(
  parameter int TEMP_CYCLES = acm_pkg::TEMP_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic int_o,
  output logic int_oe_o,
  input wire logic scan_auto_i,
  input wire logic [acm_pkg::NCH-1:0] chan_en_i,
  input wire logic [acm_pkg::NPAIR-1:0] diff_i,
  input wire logic [acm_pkg::NPAIR-1:0] bipolar_i,
  input wire logic [acm_pkg::NAIN-1:0] temp_i,
  input wire logic avg_en_i,
  input wire logic [acm_pkg::FLT_BITS-1:0] fault_lim_i,
  input wire logic [acm_pkg::WAIT_BITS-1:0] wait_i,
  input wire logic int_od_i,
  input wire logic int_pol_i,
  input wire logic [acm_pkg::NCH-1:0][acm_pkg::RES_BITS-1:0] upper_i,
  input wire logic [acm_pkg::NCH-1:0][acm_pkg::RES_BITS-1:0] lower_i,
  input wire logic signed [acm_pkg::RAW_BITS-1:0] adc_code_i,
  output logic start_o,
  output logic [3:0] pos_sel_o,
  output logic [3:0] neg_sel_o,
  output logic [acm_pkg::NCH-1:0] alarm_o
);
  import acm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    acm_state_e st;
    logic [3:0] ch;
    logic [1:0] avg;
    logic signed [12:0] acc;
    logic man;
    logic [3:0] man_ch;
    logic [13:0] wcnt;
    logic start;
    logic acq;
    logic [3:0] pos;
    logic [3:0] neg;
    logic [NCH-1:0][RES_BITS-1:0] data;
    logic [NCH-1:0][FLT_BITS-1:0] fcnt;
    logic [NCH-1:0] alarm;
    logic [TX_BITS-1:0] tx;
    logic intr;
    logic int_oe;
  } acm_top_s;
  acm_top_s q, next_q;

  acm_ser_if ser ();
  acm_conv_if cv ();

  acm_spi u_spi (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cs_n_i(cs_n_i),
    .sclk_i(sclk_i),
    .din_i(din_i),
    .dout_o(dout_o),
    .dout_oe_o(dout_oe_o),
    .s(ser.port)
  );

  acm_conv #(.TEMP_CYCLES(TEMP_CYCLES)) u_conv (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .c(cv.conv)
  );

  // ----------------------------------------------------------------
  // Channel attributes
  // ----------------------------------------------------------------
  function automatic logic [1:0] pair_of(input logic [3:0] ch);
    return 2'((ch - ADDR_ANALOG_INPUT_0) >> 1);
  endfunction

  function automatic logic is_diff(input logic [3:0] ch);
    return ch >= ADDR_ANALOG_INPUT_0 && diff_i[pair_of(ch)];
  endfunction

  function automatic logic is_temp(input logic [3:0] ch);
    return ch == ADDR_TEMP || (ch >= ADDR_ANALOG_INPUT_0 && temp_i[3'(ch - ADDR_ANALOG_INPUT_0)]);
  endfunction

  // Single-ended inputs never take the bipolar setting.
  function automatic logic is_sgn(input logic [3:0] ch);
    return is_temp(ch) || (is_diff(ch) && bipolar_i[pair_of(ch)]);
  endfunction

  // The odd member of a differential pair is never converted on its own.
  function automatic logic usable(input logic [3:0] ch);
    return ch < 4'(NCH) && !(is_diff(ch) && ch[0]);
  endfunction

  function automatic logic [4:0] next_from(input logic [3:0] from);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (4'(i) >= from && chan_en_i[i] && usable(4'(i))) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [RES_BITS-1:0] code(input logic signed [RAW_BITS:0] r, input logic sgn);
    logic [RES_BITS-1:0] v;
    v = r[RES_BITS-1:0];
    if (sgn) begin
      if (r < 12'shE00) v = 10'h200;
      else if (r > 12'sh1FF) v = 10'h1FF;
    end else begin
      if (r < 12'sh000) v = 10'h000;
      else if (r > 12'sh3FF) v = 10'h3FF;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [4:0] nf_first, nf_after;
  logic sgn_c;
  logic [RES_BITS-1:0] smp, val;
  logic signed [12:0] sum;
  logic viol, lo_hit, hi_hit;
  logic [FLT_BITS-1:0] fc;
  logic [3:0] a;
  logic act, lvl;

  always_comb begin
    next_q = q;
    next_q.start = 1'b0;
    // Evaluated here so that a change on the configuration ports alone reaches them.
    nf_first = next_from(4'h0);
    nf_after = next_from(q.ch + 4'h1);
    sgn_c = is_sgn(q.ch);
    a = ser.cmd[3:0];
    smp = code(cv.res, sgn_c);
    sum = q.acc + (sgn_c ? {{3{smp[RES_BITS-1]}}, smp} : {3'h0, smp});
    val = avg_en_i ? sum[AVG_LOG +: RES_BITS] : sum[RES_BITS-1:0];
    hi_hit = sgn_c ? $signed(val) > $signed(upper_i[q.ch]) : val > upper_i[q.ch];
    lo_hit = sgn_c ? $signed(val) < $signed(lower_i[q.ch]) : val < lower_i[q.ch];
    viol = hi_hit || lo_hit;
    fc = q.fcnt[q.ch] == '1 ? q.fcnt[q.ch] : q.fcnt[q.ch] + 4'h1;

    // Command decode; clears alarms before the conversion update so a fault
    // landing in the same cycle still sets its alarm.
    if (ser.cmd_stb) begin
      unique case (ser.cmd[7:4])
        CMD_MANUAL: begin
          next_q.man = 1'b1;
          next_q.man_ch = a;
        end
        CMD_RD_ALARM: next_q.tx = {q.alarm, 14'h0000};
        CMD_RD_DATA: next_q.tx = a < 4'(NCH) ? {q.data[a], 14'h0000} : '0;
        CMD_CLR_SEL: begin
          if (a < 4'(NCH)) begin
            next_q.alarm[a] = 1'b0;
            next_q.fcnt[a] = '0;
          end
        end
        CMD_CLR_ALL: begin
          next_q.alarm = '0;
          next_q.fcnt = '0;
        end
        CMD_RESET: begin
          next_q.alarm = '0;
          next_q.fcnt = '0;
          next_q.data = '0;
          next_q.man = 1'b0;
        end
        default: next_q.tx = '0;
      endcase
    end

    unique case (q.st)
      ACM_IDLE: begin
        if (scan_auto_i && nf_first[4]) begin
          next_q.st = ACM_CONV;
          next_q.ch = nf_first[3:0];
          next_q.start = 1'b1;
          next_q.acq = 1'b0;
        end else if (ser.cs_rise && q.man) begin
          next_q.man = 1'b0;
          if (!scan_auto_i && usable(q.man_ch)) begin
            next_q.st = ACM_CONV;
            next_q.ch = q.man_ch;
            next_q.start = 1'b1;
            next_q.acq = 1'b1;
          end
        end
      end
      ACM_CONV: begin
        if (cv.done) begin
          if (avg_en_i && q.avg != AVG_LAST) begin
            next_q.acc = sum;
            next_q.avg = q.avg + 2'h1;
            next_q.start = 1'b1;
          end else begin
            next_q.acc = '0;
            next_q.avg = 2'h0;
            next_q.data[q.ch] = val;
            if (viol) begin
              next_q.fcnt[q.ch] = fc;
              if (fc > fault_lim_i) next_q.alarm[q.ch] = 1'b1;
            end
            if (q.acq) begin
              next_q.st = ACM_IDLE;
            end else if (nf_after[4]) begin
              next_q.ch = nf_after[3:0];
              next_q.start = 1'b1;
            end else begin
              next_q.st = ACM_WAIT;
              next_q.wcnt = 14'(wait_i * WAIT_CYC);
            end
          end
        end
      end
      ACM_WAIT: begin
        if (q.wcnt == 14'h0000) next_q.st = ACM_IDLE;
        else next_q.wcnt = q.wcnt - 14'h0001;
      end
      default: next_q.st = ACM_IDLE;
    endcase

    if (next_q.start) begin
      next_q.pos = next_q.ch;
      next_q.neg = is_diff(next_q.ch) ? next_q.ch + 4'h1 : SEL_GND;
    end

    // Open-drain can only pull low, so it drives whenever the pin should read low.
    act = |q.alarm;
    lvl = int_pol_i ? act : !act;
    next_q.intr = int_od_i ? 1'b0 : lvl;
    next_q.int_oe = int_od_i ? !lvl : 1'b1;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign ser.tx = q.tx;
  assign cv.start = q.start;
  always_comb begin
    cv.temp = is_temp(q.ch);
  end
  assign cv.acq = q.acq;
  assign cv.code = adc_code_i;
  assign start_o = q.start;
  assign pos_sel_o = q.pos;
  assign neg_sel_o = q.neg;
  assign alarm_o = q.alarm;
  assign int_o = q.intr;
  assign int_oe_o = q.int_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_result_in;
    q.st == ACM_CONV && cv.done && !avg_en_i;
  endsequence

  a_neg_gives_zero: assert property (s_result_in and (!sgn_c && cv.res < 12'sh000)
    |=> q.data[$past(q.ch)] == '0) else $error("negative unipolar result not zero");
  a_single_to_gnd: assert property (q.start && !is_diff(q.ch) |-> q.pos == q.ch && q.neg == SEL_GND)
    else $error("single-ended mux wrong");
  a_diff_pairing: assert property (q.start && is_diff(q.ch) |-> !q.ch[0] && q.neg == q.ch + 4'h1)
    else $error("differential pairing wrong");
  a_int_pin_level: assert property ($past(!int_od_i && (|q.alarm))
    |-> q.intr == $past(int_pol_i) && q.int_oe) else $error("interrupt level wrong");
  a_alarm_from_fault: assert property ($rose(|q.alarm)
    |-> $past(q.st == ACM_CONV && cv.done && viol && fc > fault_lim_i)) else $error("alarm without fault count");
  a_scan_ascending: assert property (q.start && !q.acq && $past(q.st) == ACM_CONV |-> q.ch >= $past(q.ch))
    else $error("scan order not ascending");
endmodule // acm_top
`default_nettype wire

//--- testbench/acm_host.sv
// Host model: serial bus master driving the monitor's command port.
// Assumes a 125 ns link clock that idles low and stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module acm_host (
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  // Sends a command, then clocks in nrd bits MSB first; select ends high.
  task automatic xfer(input logic [7:0] cmd, input int nrd, output logic [23:0] rd);
    rd = 24'h0;
    #1 cs_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      din_o = cmd[i];
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    for (int i = 0; i < nrd; i++) begin
      // Data in is not read here, so it toggles rather than hold a stale level.
      din_o = ~din_o;
      #62.5 rd = {rd[22:0], dout_i};
      sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    #62.5 cs_n_o = 1'b1;
    din_o = ~din_o;
    #62.5;
  endtask
endmodule // acm_host
`default_nettype wire

//--- testbench/acm_tb_top.sv
// Self-checking bench of the channel monitor: manual conversion table, then scan and alarm cases.
// Assumes the package, carriers, core modules and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module acm_tb_top;
  import acm_pkg::*;
  typedef struct {logic [3:0] dif; logic [3:0] bip; logic [10:0] code; logic [7:0] sel; logic [15:0] exp;} acm_row_s;
  localparam int TC = 500;
  logic mclk_i, rst_i, ce_i, scan_auto_i, avg_en_i, int_od_i, int_pol_i, cs_n, sclk, din;
  logic dout_o, dout_oe_o, int_o, int_oe_o, start_o;
  logic [NCH-1:0] chan_en_i, alarm_o;
  logic [NPAIR-1:0] diff_i, bipolar_i;
  logic [NAIN-1:0] temp_i;
  logic [FLT_BITS-1:0] fault_lim_i;
  logic [WAIT_BITS-1:0] wait_i;
  logic [NCH-1:0][RES_BITS-1:0] upper_i, lower_i;
  logic signed [RAW_BITS-1:0] adc_code_i;
  logic [3:0] pos_sel_o, neg_sel_o;
  logic [7:0] seen_q[$];
  logic [7:0] ord[4] = '{8'h1F, 8'h2F, 8'h9F, 8'h1F};
  int when_q[$];
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int base;
  logic [23:0] rd;
  acm_row_s rows[6];

  acm_top #(.TEMP_CYCLES(TC)) acm_top_i (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .din_i(din), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .int_o(int_o), .int_oe_o(int_oe_o),
    .scan_auto_i(scan_auto_i), .chan_en_i(chan_en_i), .diff_i(diff_i), .bipolar_i(bipolar_i), .temp_i(temp_i),
    .avg_en_i(avg_en_i), .fault_lim_i(fault_lim_i), .wait_i(wait_i), .int_od_i(int_od_i), .int_pol_i(int_pol_i),
    .upper_i(upper_i), .lower_i(lower_i), .adc_code_i(adc_code_i), .start_o(start_o), .pos_sel_o(pos_sel_o),
    .neg_sel_o(neg_sel_o), .alarm_o(alarm_o));
  // A released data line reads high at the host, so a late enable cannot pass unseen.
  acm_host acm_host_i (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout_oe_o ? dout_o : 1'b1));

  // ----------------------------------------------------------------
  // Clock, start monitor and checking tasks
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (start_o === 1'b1) begin
      seen_q.push_back({pos_sel_o, neg_sel_o});
      when_q.push_back(cyc);
    end
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wait_start(input int n);
    for (int k = 0; k < 20000 && seen_q.size() < n; k++) @(posedge mclk_i);
    if (seen_q.size() < n) begin
      error_cnt++;
      $display("mismatch start count expected %0d seen %0d", n, seen_q.size());
      finish_test();
    end
  endtask

  initial begin
    #900000;
    error_cnt++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{4'h0, 4'h1, 11'h155, 8'h2F, 16'h5540}, '{4'h0, 4'h0, 11'h7F0, 8'h2F, 16'h0000},
      '{4'h1, 4'h0, 11'h7F0, 8'h23, 16'h0000}, '{4'h1, 4'h1, 11'h7F0, 8'h23, 16'hFC00},
      '{4'h1, 4'h1, 11'h300, 8'h23, 16'h7FC0}, '{4'h1, 4'h0, 11'h3FF, 8'h23, 16'hFFC0}};
    rst_i = 1'b1;
    {scan_auto_i, avg_en_i, int_od_i, ce_i} = 4'b0001;
    int_pol_i = 1'b1;
    chan_en_i = 10'h206;
    {diff_i, bipolar_i, temp_i} = 16'h0000;
    fault_lim_i = 4'hF;
    wait_i = 4'h1;
    upper_i = {NCH{10'h3FF}};
    lower_i = {NCH{10'h000}};
    adc_code_i = 11'sh000;
    repeat (8) @(posedge mclk_i);
    chk("reset outputs", 24'h0, {alarm_o, start_o, dout_oe_o, dout_o, int_o, int_oe_o});
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk("idle interrupt", 24'h1, {int_o, int_oe_o});
    foreach (rows[r]) begin
      @(posedge mclk_i);
      diff_i <= rows[r].dif;
      bipolar_i <= rows[r].bip;
      adc_code_i <= rows[r].code;
      base = seen_q.size();
      acm_host_i.xfer(8'h02, 0, rd);
      wait_start(base + 1);
      chk("selects", {16'h0, rows[r].sel}, {16'h0, seen_q[base]});
      repeat (ACQ_CYC + CONV_CYC + 20) @(posedge mclk_i);
      acm_host_i.xfer(8'h22, 16, rd);
      chk("data", {8'h0, rows[r].exp}, rd);
      chk("dout enable", 24'h0, {23'h0, dout_oe_o});
    end
    @(posedge mclk_i);
    adc_code_i <= 11'sh010;
    base = seen_q.size();
    acm_host_i.xfer(8'h00, 0, rd);
    wait_start(base + 1);
    chk("temp selects", 24'h0F, {16'h0, seen_q[base]});
    repeat (500) @(posedge mclk_i);
    adc_code_i <= 11'sh030;
    repeat (ACQ_CYC + TC - 480) @(posedge mclk_i);
    acm_host_i.xfer(8'h20, 16, rd);
    chk("temperature", 24'h000800, rd);
    acm_host_i.xfer(8'hF2, 16, rd);
    chk("reserved read", 24'h0, rd);
    acm_host_i.xfer(8'h90, 0, rd);
    @(posedge mclk_i);
    {fault_lim_i, int_od_i, int_pol_i, diff_i} <= {4'h1, 1'b1, 1'b0, 4'h0};
    adc_code_i <= 11'sh155;
    upper_i <= {NCH{10'h100}};
    chan_en_i <= 10'h206;
    base = seen_q.size();
    scan_auto_i <= 1'b1;
    wait_start(base + 4);
    for (int i = 0; i < 4; i++) chk("scan order", {16'h0, ord[i]}, {16'h0, seen_q[base + i]});
    chk("wait gap", 24'h1, {23'h0, when_q[base + 3] - when_q[base + 2] >= WAIT_CYC + CONV_CYC});
    chk("alarm one fault", 24'h0, {alarm_o, int_oe_o});
    wait_start(base + 7);
    chk("alarm set", {12'h0, 10'h206, 2'b01}, {12'h0, alarm_o, int_o, int_oe_o});
    acm_host_i.xfer(8'h10, 24, rd);
    chk("alarm read", {10'h206, 14'h0}, rd);
    @(posedge mclk_i);
    {int_od_i, int_pol_i} <= 2'b01;
    repeat (3) @(posedge mclk_i);
    chk("push-pull interrupt", 24'h3, {22'h0, int_o, int_oe_o});
    {int_od_i, int_pol_i} <= 2'b10;
    scan_auto_i <= 1'b0;
    // The sequence in progress runs to its end and through its wait before the port goes quiet.
    repeat (3 * CONV_CYC + WAIT_CYC + 20) @(posedge mclk_i);
    acm_host_i.xfer(8'h82, 0, rd);
    repeat (5) @(posedge mclk_i);
    chk("clear one", {14'h0, 10'h202}, {14'h0, alarm_o});
    ce_i <= 1'b0;
    acm_host_i.xfer(8'h90, 0, rd);
    repeat (5) @(posedge mclk_i);
    chk("frozen alarm", {14'h0, 10'h202}, {14'h0, alarm_o});
    ce_i <= 1'b1;
    acm_host_i.xfer(8'h90, 0, rd);
    repeat (5) @(posedge mclk_i);
    chk("clear all", 24'h0, {alarm_o, int_oe_o});
    @(posedge mclk_i);
    avg_en_i <= 1'b1;
    chan_en_i <= 10'h003;
    upper_i <= {NCH{10'h1FF}};
    base = seen_q.size();
    scan_auto_i <= 1'b1;
    wait_start(base + 8);
    chk("average order", 24'h000F1F, {8'h0, seen_q[base + 3], seen_q[base + 4]});
    repeat (CONV_CYC + 20) @(posedge mclk_i);
    scan_auto_i <= 1'b0;
    acm_host_i.xfer(8'h21, 16, rd);
    chk("average", 24'h005540, rd);
    finish_test();
  end
endmodule // acm_tb_top
`default_nettype wire
